// file: cfdt_pkg.sv
// shared constants and types of the flexible-data-rate bit timing engine
package cfdt_pkg;

  // system clock
  localparam int  CLK_FREQ_MHZ      = 50;
  localparam int  CLK_PS            = 1000000 / CLK_FREQ_MHZ;

  // bit position is kept in picoseconds so that quanta finer than a clock stay exact on average
  localparam int  POS_W             = 23;
  typedef logic [POS_W-1:0] cfdt_pos_t;

  // quantum options
  localparam real QUANTUM_COARSE_NS = 25.0;
  localparam real QUANTUM_FINE_NS   = 12.5;
  localparam int  QUANTUM_COARSE_PS = int'(QUANTUM_COARSE_NS * 1000.0);
  localparam int  QUANTUM_FINE_PS   = int'(QUANTUM_FINE_NS * 1000.0);

  // nominal bit, coarse quantum
  localparam int  NOM_QPB_COARSE    = 80;
  localparam int  NOM_SJW_COARSE    = 16;
  localparam int  NOM_PS2_COARSE    = 16;
  // data bit, coarse quantum
  localparam int  DAT_QPB_COARSE    = 8;
  localparam int  DAT_SJW_COARSE    = 2;
  localparam int  DAT_PS2_COARSE    = 2;
  // nominal bit, fine quantum
  localparam int  NOM_QPB_FINE      = 160;
  localparam int  NOM_SJW_FINE      = 32;
  localparam int  NOM_PS2_FINE      = 32;
  // data bit, fine quantum
  localparam int  DAT_QPB_FINE      = 16;
  localparam int  DAT_SJW_FINE      = 4;
  localparam int  DAT_PS2_FINE      = 4;

  // programmed bit times
  localparam int  NOM_BIT_NS        = 2000;
  localparam int  DAT_BIT_NS        = 200;

  // recessive bits that mark an idle bus
  localparam logic [3:0] IDLE_BITS  = 4'hb;
  localparam logic [7:0] TDC_MAX    = 8'hff;

  // frame formats handled by the framer above this engine
  localparam int  STD_ID_BITS       = 11;
  localparam int  EXT_ID_BITS       = 29;
  localparam int  CLASSIC_MAX_BYTES = 8;
  localparam int  FD_MAX_BYTES      = 64;

  // fixed protocol options
  localparam logic TDC_ENABLE       = 1'b1;
  localparam logic RES_EXCEPTION_EN = 1'b0;
  localparam logic PADDING_EN       = 1'b0;
  localparam logic TRIPLE_SAMPLE    = 1'b0;

  typedef struct packed {
    cfdt_pos_t bit_ps;
    cfdt_pos_t sample_ps;
    cfdt_pos_t sjw_ps;
  } cfdt_timing_t;

  // sample point sits at quanta-per-bit minus phase segment two, sync quantum included
  localparam cfdt_timing_t NOM_COARSE = '{
    bit_ps:    cfdt_pos_t'(NOM_QPB_COARSE * QUANTUM_COARSE_PS),
    sample_ps: cfdt_pos_t'((NOM_QPB_COARSE - NOM_PS2_COARSE) * QUANTUM_COARSE_PS),
    sjw_ps:    cfdt_pos_t'(NOM_SJW_COARSE * QUANTUM_COARSE_PS)};
  localparam cfdt_timing_t DAT_COARSE = '{
    bit_ps:    cfdt_pos_t'(DAT_QPB_COARSE * QUANTUM_COARSE_PS),
    sample_ps: cfdt_pos_t'((DAT_QPB_COARSE - DAT_PS2_COARSE) * QUANTUM_COARSE_PS),
    sjw_ps:    cfdt_pos_t'(DAT_SJW_COARSE * QUANTUM_COARSE_PS)};
  localparam cfdt_timing_t NOM_FINE = '{
    bit_ps:    cfdt_pos_t'(NOM_QPB_FINE * QUANTUM_FINE_PS),
    sample_ps: cfdt_pos_t'((NOM_QPB_FINE - NOM_PS2_FINE) * QUANTUM_FINE_PS),
    sjw_ps:    cfdt_pos_t'(NOM_SJW_FINE * QUANTUM_FINE_PS)};
  localparam cfdt_timing_t DAT_FINE = '{
    bit_ps:    cfdt_pos_t'(DAT_QPB_FINE * QUANTUM_FINE_PS),
    sample_ps: cfdt_pos_t'((DAT_QPB_FINE - DAT_PS2_FINE) * QUANTUM_FINE_PS),
    sjw_ps:    cfdt_pos_t'(DAT_SJW_FINE * QUANTUM_FINE_PS)};

  localparam cfdt_pos_t CLK_STEP    = cfdt_pos_t'(CLK_PS);

  typedef enum logic [1:0] {
    CFDT_OFF,
    CFDT_INTEGRATE,
    CFDT_ACTIVE,
    CFDT_LOW_POWER
  } cfdt_mode_t;

  // one received bit handed to the framer
  typedef struct packed {
    logic value;
    logic fast;
    logic bit_err;
  } cfdt_rx_bit_t;

  localparam int RX_BIT_W = $bits(cfdt_rx_bit_t);

endpackage

// file: cfdt_pair_buf.sv
// small valid/ready buffer of flip-flop entries
`timescale 1ns/100ps
module cfdt_pair_buf #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [IW-1:0]               wr;
    logic [IW-1:0]               rd;
    logic [IW:0]                 count;
  } cfdt_buf_state_t;

  cfdt_buf_state_t st;
  cfdt_buf_state_t next_st;
  logic            push;
  logic            pop;

  assign in_ready  = (st.count != (IW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd];

  always_comb begin
    next_st = st;
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = (st.wr == IW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == IW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// file: cfdt_bit_timing.sv
// bit timing, sampling and bit stream engine of the flexible-data-rate bus node
`timescale 1ns/100ps
module cfdt_bit_timing #(
  parameter int RX_DEPTH = 2
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  enable,
  input  wire logic                  fine_quantum,
  input  wire logic                  low_power_req,
  input  wire logic                  wake_valid,
  input  wire logic                  can_rx,
  output logic                       can_tx,
  input  wire logic                  fd_frame,
  input  wire logic                  brs_recessive,
  input  wire logic                  data_phase,
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  input  wire logic                  tx_bit,
  output logic                       rx_valid,
  input  wire logic                  rx_ready,
  output cfdt_pkg::cfdt_rx_bit_t     rx_data,
  output logic                       bit_error,
  output logic                       rx_overrun,
  input  wire logic                  overrun_clear,
  output logic                       bus_idle,
  output cfdt_pkg::cfdt_mode_t       node_mode,
  output logic [7:0]                 tdc_delay,
  output logic                       tdc_enabled,
  output logic                       res_exception_enabled,
  output logic                       padding_enabled,
  output logic                       triple_sampling
);

  typedef struct packed {
    logic                   rx_meta;
    logic                   rx_sync;
    logic                   rx_prev;
    cfdt_pkg::cfdt_mode_t   mode;
    logic                   fine;
    cfdt_pkg::cfdt_pos_t    pos;
    logic                   fast;
    logic                   sampled;
    logic                   resynced;
    logic                   ssp_done;
    logic                   tx_level;
    logic                   tx_active;
    logic [1:0]             tx_hist;
    logic [3:0]             idle_cnt;
    logic                   tdc_run;
    logic [7:0]             tdc_cnt;
    logic [7:0]             tdc_delay;
    logic                   push;
    cfdt_pkg::cfdt_rx_bit_t push_data;
    logic                   bit_err;
    logic                   overrun;
  } cfdt_state_t;

  cfdt_state_t            st;
  cfdt_state_t            next_st;
  cfdt_pkg::cfdt_timing_t nom_t;
  cfdt_pkg::cfdt_timing_t dat_t;
  cfdt_pkg::cfdt_timing_t cur_t;
  cfdt_pkg::cfdt_pos_t    pos_inc;
  cfdt_pkg::cfdt_pos_t    pos_n;
  cfdt_pkg::cfdt_pos_t    lag;
  cfdt_pkg::cfdt_pos_t    remain;
  cfdt_pkg::cfdt_pos_t    tdc_ps;
  cfdt_pkg::cfdt_pos_t    ssp_total;
  cfdt_pkg::cfdt_pos_t    ssp_pos;
  logic                   ssp_wrap;
  logic                   fall;
  logic                   running;
  logic                   bit_end;
  logic                   take_tx;
  logic                   buf_in_ready;
  logic                   idle_now;

  cfdt_pair_buf #(
    .WIDTH (cfdt_pkg::RX_BIT_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_buf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (st.push),
    .in_ready  (buf_in_ready),
    .in_data   (st.push_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // both phases select from one quantum option, reloaded on entering active and frozen there
  always_comb begin
    nom_t = st.fine ? cfdt_pkg::NOM_FINE : cfdt_pkg::NOM_COARSE;
    dat_t = st.fine ? cfdt_pkg::DAT_FINE : cfdt_pkg::DAT_COARSE;
    cur_t = st.fast ? dat_t : nom_t;
  end

  assign idle_now  = (st.idle_cnt == cfdt_pkg::IDLE_BITS);
  assign fall      = st.rx_prev && !st.rx_sync;
  assign running   = (st.mode == cfdt_pkg::CFDT_INTEGRATE) || (st.mode == cfdt_pkg::CFDT_ACTIVE);

  // secondary sample point for own bits in the fast phase
  always_comb begin
    tdc_ps    = cfdt_pkg::cfdt_pos_t'(st.tdc_delay) * cfdt_pkg::CLK_STEP;
    ssp_total = tdc_ps + dat_t.sample_ps;
    ssp_wrap  = (ssp_total >= dat_t.bit_ps);
    ssp_pos   = ssp_wrap ? ssp_total - dat_t.bit_ps : ssp_total;
  end

  always_comb begin
    next_st                 = st;
    next_st.rx_meta         = can_rx;
    next_st.rx_sync         = st.rx_meta;
    next_st.rx_prev         = st.rx_sync;
    next_st.push            = 1'b0;
    next_st.bit_err         = 1'b0;
    pos_inc                 = st.pos + cfdt_pkg::CLK_STEP;
    pos_n                   = pos_inc;
    lag                     = '0;
    remain                  = '0;
    bit_end                 = 1'b0;
    take_tx                 = 1'b0;
    tx_ready                = 1'b0;

    // a bit the buffer cannot take is flagged, never silently dropped; a new loss wins over the clear
    next_st.overrun = (st.push && !buf_in_ready) || (st.overrun && !overrun_clear);

    if (!enable) begin
      // supply failing or node switched off: release the bus at once
      next_st.mode      = cfdt_pkg::CFDT_OFF;
      next_st.tx_level  = 1'b1;
      next_st.tx_active = 1'b0;
      next_st.pos       = '0;
      next_st.idle_cnt  = '0;
      next_st.tdc_run   = 1'b0;
    end else if (low_power_req && st.mode != cfdt_pkg::CFDT_OFF) begin
      // entered whatever the bus level, no wait for an idle bus
      next_st.mode      = cfdt_pkg::CFDT_LOW_POWER;
      next_st.tx_level  = 1'b1;
      next_st.tx_active = 1'b0;
      next_st.pos       = '0;
      next_st.idle_cnt  = '0;
      next_st.tdc_run   = 1'b0;
    end else begin
      case (st.mode)
        cfdt_pkg::CFDT_OFF: begin
          // power back: listen for an idle bus before driving anything
          next_st.mode     = cfdt_pkg::CFDT_INTEGRATE;
          next_st.fine     = fine_quantum;
          next_st.idle_cnt = '0;
          next_st.pos      = '0;
          next_st.fast     = 1'b0;
        end
        cfdt_pkg::CFDT_LOW_POWER: begin
          if (wake_valid) begin
            next_st.mode     = cfdt_pkg::CFDT_INTEGRATE;
            next_st.fine     = fine_quantum;
            next_st.idle_cnt = '0;
            next_st.fast     = 1'b0;
          end
        end
        cfdt_pkg::CFDT_INTEGRATE,
        cfdt_pkg::CFDT_ACTIVE: begin
          // synchronisation on recessive to dominant edges not caused by ourselves
          if (fall && idle_now && st.tx_level) begin
            pos_n            = cfdt_pkg::CLK_STEP;
            next_st.sampled  = 1'b0;
            next_st.resynced = 1'b1;
            next_st.ssp_done = 1'b0;
          end else if (fall && !st.resynced && st.tx_level && !(st.fast && st.tx_active)) begin
            next_st.resynced = 1'b1;
            if (st.pos < cur_t.sample_ps) begin
              lag   = st.pos;
              pos_n = pos_inc - ((lag < cur_t.sjw_ps) ? lag : cur_t.sjw_ps);
            end else begin
              remain = cur_t.bit_ps - st.pos;
              pos_n  = (remain <= cur_t.sjw_ps) ? cur_t.bit_ps : pos_inc + cur_t.sjw_ps;
            end
          end

          // one sample at the sample point, no majority vote
          if (!st.sampled && pos_n >= cur_t.sample_ps) begin
            next_st.sampled         = 1'b1;
            next_st.push            = 1'b1;
            next_st.push_data.value = st.rx_sync;
            next_st.push_data.fast  = st.fast;
            // checks run on every own bit of the nominal phase regardless of its value
            next_st.push_data.bit_err = st.tx_active && !st.fast && (st.rx_sync != st.tx_level);
            next_st.bit_err           = st.tx_active && !st.fast && (st.rx_sync != st.tx_level);
            if (st.rx_sync) begin
              next_st.idle_cnt = idle_now ? st.idle_cnt : st.idle_cnt + 4'h1;
            end else begin
              next_st.idle_cnt = '0;
            end
          end

          // own fast bits checked at the delay-compensated point
          if (st.fast && st.tx_active && !st.ssp_done && pos_n >= ssp_pos) begin
            next_st.ssp_done = 1'b1;
            if (st.rx_sync != (ssp_wrap ? st.tx_hist[1] : st.tx_hist[0])) begin
              next_st.bit_err = 1'b1;
            end
          end

          // transmitter delay measured on own falling edge in the nominal phase
          if (st.tdc_run) begin
            if (fall) begin
              next_st.tdc_run   = 1'b0;
              next_st.tdc_delay = st.tdc_cnt;
            end else if (st.tdc_cnt != cfdt_pkg::TDC_MAX) begin
              next_st.tdc_cnt = st.tdc_cnt + 8'h01;
            end
          end

          bit_end = (pos_n >= cur_t.bit_ps);
          if (bit_end) begin
            next_st.pos      = pos_n - cur_t.bit_ps;
            next_st.sampled  = 1'b0;
            next_st.resynced = 1'b0;
            next_st.ssp_done = 1'b0;
            next_st.fast     = (st.mode == cfdt_pkg::CFDT_ACTIVE) && data_phase && fd_frame
                               && brs_recessive;
            tx_ready         = (st.mode == cfdt_pkg::CFDT_ACTIVE);
            take_tx          = tx_ready && tx_valid;
            next_st.tx_level  = take_tx ? tx_bit : 1'b1;
            next_st.tx_active = take_tx;
            next_st.tx_hist   = {st.tx_hist[0], take_tx ? tx_bit : 1'b1};
            if (st.tx_level && take_tx && !tx_bit && !next_st.fast) begin
              next_st.tdc_run = 1'b1;
              next_st.tdc_cnt = '0;
            end
          end else begin
            next_st.pos = pos_n;
          end

          if (st.mode == cfdt_pkg::CFDT_INTEGRATE && idle_now) begin
            next_st.mode = cfdt_pkg::CFDT_ACTIVE;
            next_st.fine = fine_quantum;
          end
        end
        default: begin
          next_st.mode     = cfdt_pkg::CFDT_OFF;
          next_st.tx_level = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st          <= '0;
      st.rx_meta  <= 1'b1;
      st.rx_sync  <= 1'b1;
      st.rx_prev  <= 1'b1;
      st.mode     <= cfdt_pkg::CFDT_OFF;
      st.tx_level <= 1'b1;
      st.tx_hist  <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign can_tx                = st.tx_level;
  assign bit_error             = st.bit_err;
  assign rx_overrun            = st.overrun;
  assign bus_idle              = idle_now;
  assign node_mode             = st.mode;
  assign tdc_delay             = st.tdc_delay;
  assign tdc_enabled           = cfdt_pkg::TDC_ENABLE;
  assign res_exception_enabled = cfdt_pkg::RES_EXCEPTION_EN;
  assign padding_enabled       = cfdt_pkg::PADDING_EN;
  assign triple_sampling       = cfdt_pkg::TRIPLE_SAMPLE;

endmodule

// file: cfdt_bus_peer.sv
// far-side bus model: wired-and of the node's own bits, echoed with a chosen loop delay
`timescale 1ns/100ps
module cfdt_bus_peer (
  input  wire logic       ref_clk,
  input  wire logic       node_tx,
  input  wire logic       stuck_dom,
  input  wire logic [1:0] lag,
  output logic            bus
);
  // bus pull-up keeps the line recessive until the node drives
  logic [2:0] dly = 3'h7;
  logic       echo;

  always_ff @(posedge ref_clk) begin
    dly <= {dly[1:0], node_tx};
  end

  // a slow transceiver answers up to three clocks late
  assign echo = (lag == 2'h0) ? node_tx : dly[lag - 2'h1];
  assign bus  = stuck_dom ? 1'b0 : echo;
endmodule

// file: cfdt_bit_timing_asserts.sv
// concurrent checks on the ports of the bit timing engine
`timescale 1ns/100ps
module cfdt_bit_timing_asserts (
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  input wire logic                   enable,
  input wire logic                   low_power_req,
  input wire logic                   can_tx,
  input wire logic                   fd_frame,
  input wire logic                   brs_recessive,
  input wire logic                   data_phase,
  input wire logic                   tx_valid,
  input wire logic                   tx_ready,
  input wire logic                   tx_bit,
  input wire logic                   rx_valid,
  input wire logic                   rx_ready,
  input wire cfdt_pkg::cfdt_rx_bit_t rx_data,
  input wire logic                   rx_overrun,
  input wire logic                   overrun_clear,
  input wire logic                   bus_idle,
  input wire cfdt_pkg::cfdt_mode_t   node_mode,
  input wire logic                   tdc_enabled,
  input wire logic                   res_exception_enabled,
  input wire logic                   padding_enabled,
  input wire logic                   triple_sampling
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // cycles since the last bit boundary, and whether the bit ran wholly slow or wholly fast
  logic [7:0] gap;
  logic       seen;
  logic       slow;
  logic       fast;
  logic       lv;

  assign lv = fd_frame & brs_recessive & data_phase;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || node_mode != cfdt_pkg::CFDT_ACTIVE) begin
      gap  <= 8'h0;
      seen <= 1'b0;
      slow <= 1'b0;
      fast <= 1'b0;
    end else if (tx_ready) begin
      gap  <= 8'h1;
      seen <= 1'b1;
      slow <= !lv & !bus_idle;
      fast <= lv;
    end else begin
      gap  <= (gap == 8'hff) ? gap : gap + 8'h1;
      slow <= slow & !lv & !bus_idle;
      fast <= fast & lv;
    end
  end

  a_tdc_on: assert property (tdc_enabled) else $error("tdc disabled");
  a_res_exc_off: assert property (!res_exception_enabled) else $error("reserved exception on");
  a_pad_off: assert property (!padding_enabled) else $error("padding on");
  a_single_sample: assert property (!triple_sampling) else $error("triple sampling on");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> can_tx && node_mode == cfdt_pkg::CFDT_OFF)
    else $error("bus driven during reset");
  a_power_loss: assert property (!enable |=> can_tx && node_mode == cfdt_pkg::CFDT_OFF)
    else $error("bus driven without power");
  a_low_quiet: assert property (node_mode == cfdt_pkg::CFDT_LOW_POWER &&
    $past(node_mode) == cfdt_pkg::CFDT_LOW_POWER |-> can_tx) else $error("bus driven in low power");
  a_low_enter: assert property (enable && low_power_req &&
    (node_mode == cfdt_pkg::CFDT_INTEGRATE || node_mode == cfdt_pkg::CFDT_ACTIVE)
    |-> ##[1:2] (node_mode == cfdt_pkg::CFDT_LOW_POWER || !enable)) else $error("low power not entered");
  a_low_stay: assert property (enable && low_power_req && node_mode == cfdt_pkg::CFDT_LOW_POWER
    |=> node_mode == cfdt_pkg::CFDT_LOW_POWER) else $error("low power left early");
  a_integ_quiet: assert property (node_mode == cfdt_pkg::CFDT_INTEGRATE |-> can_tx)
    else $error("bus driven while integrating");
  a_tx_drive: assert property (tx_ready && tx_valid && enable && !low_power_req
    |=> can_tx == $past(tx_bit)) else $error("taken bit not driven");
  a_nom_bit: assert property (tx_ready && seen && slow |-> gap >= 8'h4e && gap <= 8'h7a)
    else $error("nominal bit length wrong");
  a_fast_bit: assert property (tx_ready && seen && fast |-> gap >= 8'h07 && gap <= 8'h0d)
    else $error("data bit length wrong");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received bit dropped while stalled");
  a_ovr_sticky: assert property (rx_overrun && !overrun_clear |=> rx_overrun)
    else $error("overrun flag lost");

  c_low_power: cover property (node_mode == cfdt_pkg::CFDT_LOW_POWER);
  c_overrun: cover property (rx_overrun);
  c_fast_bit: cover property (tx_ready && seen && fast);
endmodule

bind cfdt_bit_timing cfdt_bit_timing_asserts i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .enable(enable),
  .low_power_req(low_power_req), .can_tx(can_tx), .fd_frame(fd_frame), .brs_recessive(brs_recessive),
  .data_phase(data_phase), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_bit(tx_bit), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun), .overrun_clear(overrun_clear),
  .bus_idle(bus_idle), .node_mode(node_mode), .tdc_enabled(tdc_enabled),
  .res_exception_enabled(res_exception_enabled), .padding_enabled(padding_enabled),
  .triple_sampling(triple_sampling));

// file: cfdt_bit_timing_test.sv
// self-checking bench of the bit timing engine
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cfdt_bit_timing_test;
  logic                   ref_clk, sys_rst, enable, fine_quantum, low_power_req, wake_valid, can_rx, can_tx;
  logic                   fd_frame, brs_recessive, data_phase, tx_valid, tx_ready, tx_bit, rx_valid, rx_ready;
  logic                   bit_error, rx_overrun, overrun_clear, bus_idle, stuck, tdc_en, res_en, pad_en, trip;
  logic [7:0]             tdc_delay;
  logic [1:0]             lag;
  cfdt_pkg::cfdt_rx_bit_t rx_data;
  cfdt_pkg::cfdt_mode_t   node_mode;
  int                     n_fail, checks, cyc, n_err;
  logic [31:0]            seed;
  logic [1:0]             exp_q[$];
  logic [1:0]             got_q[$];

  cfdt_bit_timing i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .enable(enable), .fine_quantum(fine_quantum),
    .low_power_req(low_power_req), .wake_valid(wake_valid), .can_rx(can_rx), .can_tx(can_tx),
    .fd_frame(fd_frame), .brs_recessive(brs_recessive), .data_phase(data_phase), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_bit(tx_bit), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .bit_error(bit_error), .rx_overrun(rx_overrun), .overrun_clear(overrun_clear), .bus_idle(bus_idle),
    .node_mode(node_mode), .tdc_delay(tdc_delay), .tdc_enabled(tdc_en), .res_exception_enabled(res_en),
    .padding_enabled(pad_en), .triple_sampling(trip));
  cfdt_bus_peer i_peer (.ref_clk(ref_clk), .node_tx(can_tx), .stuck_dom(stuck), .lag(lag), .bus(can_rx));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // every popped bit is logged with its fast flag
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back({rx_data.value, rx_data.fast});
    if (bit_error === 1'b1) n_err++;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end

  task summarize;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task wait_mode(input cfdt_pkg::cfdt_mode_t m);
    int i;
    i = 0;
    while (node_mode !== m && i < 2000) begin
      @(negedge ref_clk);
      i++;
    end
    `CHK(node_mode, m)
  endtask

  // sends n random bits with framer levels lv = {fd, brs, data phase}, checking bit spacing
  task send(input int n, input int gap, input logic [2:0] lv);
    int k, since, i;
    k = 0;
    since = 0;
    i = 0;
    {fd_frame, brs_recessive, data_phase} = lv;
    tx_valid = 1'b1;
    while (k < n && i < 5000) begin
      @(negedge ref_clk);
      i++;
      since++;
      if (tx_ready === 1'b1) begin
        if (k > 1) `CHK(since >= gap - 1 && since <= gap + 1, 1'b1)
        if (exp_q.size() == 0) got_q.delete();
        exp_q.push_back({tx_bit, &lv});
        k++;
        @(negedge ref_clk);
        since = 1;
        seed = lfsr(seed);
        tx_bit = seed[0];
      end
    end
  endtask

  // cuts power or resets while a dominant bit is on the bus
  task kill(input logic rst);
    int i;
    i = 0;
    tx_valid = 1'b1;
    tx_bit = 1'b0;
    while (can_tx !== 1'b0 && i < 400) begin
      @(negedge ref_clk);
      i++;
    end
    if (rst) sys_rst = 1'b1;
    else enable = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK(can_tx, 1'b1)
    `CHK(node_mode, cfdt_pkg::CFDT_OFF)
    `CHK(bus_idle, 1'b0)
    sys_rst = 1'b0;
    enable = 1'b1;
    tx_valid = 1'b0;
  endtask

  initial begin
    seed = 32'ha265e4b7;
    {sys_rst, enable, fine_quantum, low_power_req, wake_valid, fd_frame, brs_recessive} = 7'h60;
    {data_phase, tx_valid, tx_bit, rx_ready, overrun_clear, stuck} = 6'h04;
    lag = 2'h0;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    n_err = 0;
    repeat (5) @(negedge ref_clk);
    `CHK(can_tx, 1'b1)
    `CHK({tdc_en, res_en, pad_en, trip}, 4'h8)
    sys_rst = 1'b0;
    for (int fq = 0; fq < 2; fq++) begin
      fine_quantum = fq[0];
      lag = fq[0] ? 2'h2 : 2'h0;
      if (fq == 1) kill(1'b1);
      wait_mode(cfdt_pkg::CFDT_ACTIVE);
      exp_q.delete();
      tx_bit = 1'b0;
      send(12, 100, 3'h0);
      send(24, 10, 3'h7);
      send(4, 100, 3'h3);
      send(4, 100, 3'h6);
      send(4, 100, 3'h0);
      tx_valid = 1'b0;
      repeat (200) @(negedge ref_clk);
      `CHK(got_q.size() >= exp_q.size(), 1'b1)
      foreach (exp_q[i]) `CHK(got_q[i], exp_q[i])
      `CHK(n_err, 0)
      `CHK(tdc_delay > 8'h0 && tdc_delay < 8'h0c, 1'b1)
    end
    rx_ready = 1'b0;
    repeat (500) @(negedge ref_clk);
    `CHK(rx_valid, 1'b1)
    `CHK(rx_overrun, 1'b1)
    rx_ready = 1'b1;
    overrun_clear = 1'b1;
    repeat (4) @(negedge ref_clk);
    overrun_clear = 1'b0;
    `CHK(rx_overrun, 1'b0)
    `CHK(rx_valid, 1'b0)
    stuck = 1'b1;
    low_power_req = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK(node_mode, cfdt_pkg::CFDT_LOW_POWER)
    wake_valid = 1'b1;
    repeat (300) @(negedge ref_clk);
    `CHK(node_mode, cfdt_pkg::CFDT_LOW_POWER)
    `CHK(can_tx, 1'b1)
    low_power_req = 1'b0;
    repeat (2) @(negedge ref_clk);
    wake_valid = 1'b0;
    `CHK(node_mode, cfdt_pkg::CFDT_INTEGRATE)
    stuck = 1'b0;
    wait_mode(cfdt_pkg::CFDT_ACTIVE);
    kill(1'b0);
    wait_mode(cfdt_pkg::CFDT_ACTIVE);
    summarize();
  end
endmodule
